// *** bench/dafr_alarm_sva.sv ***
// Checker for the alarm status register port
`timescale 1ns/100ps
module dafr_alarm_sva (
  input wire core_clk,
  input wire rst,
  input wire [6:0] regSlaveAddr,
  input wire [7:0] regAddr,
  input wire regRead,
  input wire regWrite,
  input wire regHit,
  input wire [7:0] regRdata,
  input wire powerOnBusy
);
  wire sel = regRead && regSlaveAddr == 7'h51;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  rst_a: assert property ($fell(rst) |-> powerOnBusy && !regRdata)
    else $error("bad reset state");
  hit_low_a: assert property (sel && regAddr == 8'h70 |-> regHit)
    else $error("no hit on low byte");
  hit_other_a: assert property (regSlaveAddr != 7'h51 |-> !regHit)
    else $error("hit on other address");
  rsvd_zero_a:
    assert property (sel && regAddr == 8'h71 |=> !regRdata[5:0])
    else $error("reserved bits set");
  unmapped_a:
    assert property (sel && (regAddr < 8'h70 || regAddr > 8'h71) |=> !regRdata)
    else $error("unmapped offset not zero");
  busy_zero_a: assert property (sel && powerOnBusy |=> !regRdata)
    else $error("flag before first cycle");
  hold_data_a: assert property (!sel |=> $stable(regRdata))
    else $error("read data moved");
  busy_stay_a: assert property (!powerOnBusy |=> !powerOnBusy)
    else $error("busy came back");
  cover property (regRead && regHit);
  cover property ($fell(powerOnBusy));
  cover property (regWrite && regHit);
endmodule // dafr_alarm_sva

bind dafr_alarm_flags dafr_alarm_sva chk_u (.core_clk, .rst, .regSlaveAddr,
  .regAddr, .regRead, .regWrite, .regHit, .regRdata, .powerOnBusy);

// *** bench/dafr_host_model.sv ***
// Host model issuing single byte transfers on the register port
`timescale 1ns/100ps
module dafr_host_model (
  input wire core_clk,
  input wire regHit,
  input wire [7:0] regRdata,
  output reg [6:0] regSlaveAddr = 7'h51,
  output reg [7:0] regAddr = 8'h00,
  output reg regRead = 1'b0,
  output reg regWrite = 1'b0,
  output reg [7:0] regWdata = 8'h00
);
  task xfer(input [6:0] s, input [7:0] a, input w, input [7:0] d,
    output h, output [7:0] q);
  begin
    @(posedge core_clk) #1;
    regSlaveAddr = s;
    regAddr = a;
    regWdata = d;
    regWrite = w;
    regRead = !w;
    @(posedge core_clk);
    h = regHit;
    #1;
    regRead = 1'b0;
    regWrite = 1'b0;
    // Offset and write data toggle so stale values never look valid; the slave address is kept
    regAddr = ~regAddr;
    regWdata = ~regWdata;
    q = regRdata;
  end
  endtask
endmodule // dafr_host_model

// *** bench/tb.sv ***
// Testbench for the alarm status bytes
`timescale 1ns/100ps
module tb;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg convDone = 1'b0;
  reg [2:0] convChannel = 3'h0;
  reg [15:0] convValue = 16'h0000;
  reg cycleDone = 1'b0;
  reg [15:0] hiLim = 16'h8000;
  reg [15:0] loLim = 16'h4000;
  wire [6:0] regSlaveAddr;
  wire [7:0] regAddr, regWdata, regRdata;
  wire regRead, regWrite, regHit, powerOnBusy;
  integer failures = 0;
  integer checkCount = 0;
  integer c, k;
  reg hit;
  reg [7:0] q;
  reg [15:0] e;
  initial forever #50 core_clk = ~core_clk;
  dafr_alarm_flags dut_u (.core_clk, .rst, .convDone, .convChannel,
    .convValue, .cycleDone, .thermal_upper_limit(hiLim),
    .thermal_lower_limit(loLim), .supply_upper_limit(hiLim),
    .supply_lower_limit(loLim), .laser_current_upper_limit(hiLim),
    .laser_current_lower_limit(loLim), .launch_power_upper_limit(hiLim),
    .launch_power_lower_limit(loLim), .received_power_upper_limit(hiLim),
    .received_power_lower_limit(loLim), .regSlaveAddr, .regAddr, .regRead,
    .regWrite, .regWdata, .regHit, .regRdata, .powerOnBusy);
  dafr_host_model host_u (.core_clk, .regHit, .regRdata, .regSlaveAddr,
    .regAddr, .regRead, .regWrite, .regWdata);
  task chk(input string nm, input [7:0] ex, input [7:0] got);
  begin
    checkCount = checkCount + 1;
    if (got !== ex)
    begin
      failures = failures + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  end
  endtask
  task conv(input [2:0] ch, input [15:0] v, input cd);
  begin
    @(posedge core_clk) #1;
    convDone = 1'b1;
    convChannel = ch;
    convValue = v;
    cycleDone = cd;
    @(posedge core_clk) #1;
    convDone = 1'b0;
    cycleDone = 1'b0;
    convValue = ~v;
  end
  endtask
  task rd(input [6:0] s, input [7:0] a);
    host_u.xfer(s, a, 1'b0, 8'h00, hit, q);
  endtask
  task t_reset;
  begin
    rd(7'h51, 8'h70);
    chk("low byte", 8'h00, q);
    rd(7'h51, 8'h71);
    chk("high byte", 8'h00, q);
    chk("busy", 8'h01, {7'h00, powerOnBusy});
  end
  endtask
  task t_power;
  begin
    for (c = 0; c < 4; c = c + 1)
      conv(c[2:0], 16'hFFFF, 1'b0);
    conv(3'h7, 16'hFFFF, 1'b1);
    chk("busy early", 8'h01, {7'h00, powerOnBusy});
    rd(7'h51, 8'h70);
    chk("hidden flags", 8'h00, q);
    conv(3'h4, 16'h0000, 1'b1);
    @(posedge core_clk) #1;
    chk("busy done", 8'h00, {7'h00, powerOnBusy});
    rd(7'h51, 8'h70);
    chk("power-up flags", 8'hAA, q);
    rd(7'h51, 8'h71);
    chk("power-up high", 8'h40, q);
    // Bring every channel back to normal before the per-channel scenario
    for (c = 0; c < 5; c = c + 1)
      conv(c[2:0], 16'h6000, 1'b0);
    rd(7'h51, 8'h70);
    chk("recovered low", 8'h00, q);
    rd(7'h51, 8'h71);
    chk("recovered high", 8'h00, q);
  end
  endtask
  task t_flags;
  begin
    for (c = 0; c < 5; c = c + 1)
      for (k = 0; k < 3; k = k + 1)
      begin
        // Third value equals the upper limit and must read as normal
        conv(c[2:0], k == 0 ? 16'h9000 : k == 1 ? 16'h3000 : 16'h8000, 1'b0);
        e = 16'h0000;
        if (k < 2)
          e[(c < 4 ? 15 - 2 * c : 7) - k] = 1'b1;
        rd(7'h51, 8'h70);
        chk("low byte", e[15:8], q);
        rd(7'h51, 8'h71);
        chk("high byte", e[7:0], q);
        chk("hit", 8'h01, {7'h00, hit});
      end
  end
  endtask
  task t_write;
  begin
    conv(3'h2, 16'h9000, 1'b0);
    host_u.xfer(7'h51, 8'h70, 1'b1, 8'hFF, hit, q);
    chk("write hit", 8'h01, {7'h00, hit});
    rd(7'h51, 8'h70);
    chk("after write", 8'h08, q);
    rd(7'h51, 8'h72);
    chk("unmapped", 8'h00, q);
    rd(7'h50, 8'h70);
    chk("other addr", 8'h00, q);
    chk("other hit", 8'h00, {7'h00, hit});
  end
  endtask
  task wrap_up;
  begin
    $display("checks %0d failures %0d", checkCount, failures);
    if (failures == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    failures = failures + 1;
    wrap_up;
  end
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_power;
    t_flags;
    t_write;
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset;
    wrap_up;
  end
endmodule // tb

// *** include/dafr_defs.vh ***
// Offsets, field positions, reset values and channel codes for the alarm flags
`ifndef DAFR_DEFS_VH
`define DAFR_DEFS_VH
`define DAFR_SERIAL_ADDR 7'h51
`define DAFR_ALARM_LOW_OFFSET 8'h70
`define DAFR_ALARM_HIGH_OFFSET 8'h71
`define DAFR_ALARM_RESET 8'h00
`define DAFR_RSVD_MASK 8'hC0
`define DAFR_BIT_OVER_HEAT 7
`define DAFR_BIT_UNDER_HEAT 6
`define DAFR_BIT_SUPPLY_OVER 5
`define DAFR_BIT_SUPPLY_UNDER 4
`define DAFR_BIT_BIAS_OVER 3
`define DAFR_BIT_BIAS_UNDER 2
`define DAFR_BIT_TX_OVER 1
`define DAFR_BIT_TX_UNDER 0
`define DAFR_BIT_RX_OVER 7
`define DAFR_BIT_RX_UNDER 6
`define DAFR_CH_THERMAL 3'h0
`define DAFR_CH_SUPPLY 3'h1
`define DAFR_CH_BIAS 3'h2
`define DAFR_CH_TXPWR 3'h3
`define DAFR_CH_RXPWR 3'h4
`define DAFR_NUM_CH 5
`define DAFR_ALL_SEEN 5'h1F
`endif

// *** rtl/dafr_alarm_flags.v ***
// Alarm status bytes at offsets 70h and 71h of the diagnostic space
//
// Summary of operation
// (RULE_01) The first alarm byte sits at offset 112 of the A2h space, read-only.
// (RULE_02) Both bytes read 00h from reset until the first full cycle ends.
// (RULE_03) A flag reads 1 while its condition exists, else 0.
// (RULE_04) Byte 112 bit 7 is thermal over, bit 6 thermal under.
// (RULE_05) Byte 112 bit 5 is supply over, bit 4 supply under.
// (RULE_06) Byte 112 bit 3 is bias over, bit 2 bias under.
// (RULE_07) Byte 112 bit 1 is transmit power over, bit 0 transmit under.
// (RULE_08) Byte 113 bit 7 is receive overload, bit 6 receive under.
// (RULE_09) Byte 113 bits 5 to 0 always read zero.
// (RULE_10) A power-on status bit reads 1 until every value converted once; the code also waits for cycleDone with all seen.
// (RULE_11) Flags follow each new conversion, never latch; writes are ignored.
`timescale 1ns/100ps
`include "dafr_defs.vh"
module dafr_alarm_flags #(
  parameter WIDTH = 16
) (
  core_clk,
  rst,
  convDone,
  convChannel,
  convValue,
  cycleDone,
  thermal_upper_limit,
  thermal_lower_limit,
  supply_upper_limit,
  supply_lower_limit,
  laser_current_upper_limit,
  laser_current_lower_limit,
  launch_power_upper_limit,
  launch_power_lower_limit,
  received_power_upper_limit,
  received_power_lower_limit,
  regSlaveAddr,
  regAddr,
  regRead,
  regWrite,
  regWdata,
  regHit,
  regRdata,
  powerOnBusy
);
  input wire core_clk;
  input wire rst;
  input wire convDone;
  input wire [2:0] convChannel;
  input wire [WIDTH-1:0] convValue;
  input wire cycleDone;
  input wire [WIDTH-1:0] thermal_upper_limit;
  input wire [WIDTH-1:0] thermal_lower_limit;
  input wire [WIDTH-1:0] supply_upper_limit;
  input wire [WIDTH-1:0] supply_lower_limit;
  input wire [WIDTH-1:0] laser_current_upper_limit;
  input wire [WIDTH-1:0] laser_current_lower_limit;
  input wire [WIDTH-1:0] launch_power_upper_limit;
  input wire [WIDTH-1:0] launch_power_lower_limit;
  input wire [WIDTH-1:0] received_power_upper_limit;
  input wire [WIDTH-1:0] received_power_lower_limit;
  input wire [6:0] regSlaveAddr;
  input wire [7:0] regAddr;
  input wire regRead;
  input wire regWrite;
  input wire [7:0] regWdata;
  output wire regHit;
  output reg [7:0] regRdata;
  output wire powerOnBusy;

  localparam ST_POWERUP = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`DAFR_NUM_CH-1:0] seen_q;
  reg [`DAFR_NUM_CH-1:0] seen_d;
  reg [7:0] alarmLow_q;
  reg [7:0] alarmLow_d;
  reg [7:0] alarmHigh_q;
  reg [7:0] alarmHigh_d;
  reg [WIDTH-1:0] upperSel;
  reg [WIDTH-1:0] lowerSel;
  wire overNow;
  wire underNow;
  wire allSeen;
  wire lowSel;
  wire highSel;

  // One comparator serves all channels since conversions arrive one at a time
  dafr_compare #(
    .WIDTH(WIDTH)
  ) u_cmp (
    .reading(convValue),
    .upperLimit(upperSel),
    .lowerLimit(lowerSel),
    .overFlag(overNow),
    .underFlag(underNow)
  );

  function chanValid;
    input [2:0] ch;
    begin
      chanValid = (ch <= `DAFR_CH_RXPWR);
    end
  endfunction

  always @*
  begin
    upperSel = thermal_upper_limit;
    lowerSel = thermal_lower_limit;
    case (convChannel)
      `DAFR_CH_SUPPLY:
      begin
        upperSel = supply_upper_limit;
        lowerSel = supply_lower_limit;
      end
      `DAFR_CH_BIAS:
      begin
        upperSel = laser_current_upper_limit;
        lowerSel = laser_current_lower_limit;
      end
      `DAFR_CH_TXPWR:
      begin
        upperSel = launch_power_upper_limit;
        lowerSel = launch_power_lower_limit;
      end
      `DAFR_CH_RXPWR:
      begin
        upperSel = received_power_upper_limit;
        lowerSel = received_power_lower_limit;
      end
      default:
      begin
        upperSel = thermal_upper_limit;
        lowerSel = thermal_lower_limit;
      end
    endcase
  end

  assign allSeen = (seen_d == `DAFR_ALL_SEEN);

  always @*
  begin
    state_d = state_q;
    seen_d = seen_q;
    alarmLow_d = alarmLow_q;
    alarmHigh_d = alarmHigh_q;
    if (convDone && chanValid(convChannel))
    begin
      seen_d[convChannel] = 1'b1;
    end
    // Flags track every conversion, power-up included, so the first
    // cycle's results are in place the moment they become visible
    if (convDone)
    begin
      case (convChannel)
        `DAFR_CH_THERMAL:
        begin
          alarmLow_d[`DAFR_BIT_OVER_HEAT] = overNow; // RULE_04
          alarmLow_d[`DAFR_BIT_UNDER_HEAT] = underNow; // RULE_04
        end
        `DAFR_CH_SUPPLY:
        begin
          alarmLow_d[`DAFR_BIT_SUPPLY_OVER] = overNow; // RULE_05
          alarmLow_d[`DAFR_BIT_SUPPLY_UNDER] = underNow; // RULE_05
        end
        `DAFR_CH_BIAS:
        begin
          alarmLow_d[`DAFR_BIT_BIAS_OVER] = overNow; // RULE_06
          alarmLow_d[`DAFR_BIT_BIAS_UNDER] = underNow; // RULE_06
        end
        `DAFR_CH_TXPWR:
        begin
          alarmLow_d[`DAFR_BIT_TX_OVER] = overNow; // RULE_07
          alarmLow_d[`DAFR_BIT_TX_UNDER] = underNow; // RULE_07
        end
        `DAFR_CH_RXPWR:
        begin
          alarmHigh_d[`DAFR_BIT_RX_OVER] = overNow; // RULE_08
          alarmHigh_d[`DAFR_BIT_RX_UNDER] = underNow; // RULE_08
        end
        default:
        begin
          alarmLow_d = alarmLow_q;
        end
      endcase
    end
    case (state_q)
      ST_POWERUP:
      begin
        // Results are compared but kept hidden until the first cycle ends
        if (cycleDone && allSeen) // RULE_02
        begin
          state_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_POWERUP;
      end
    endcase
    alarmHigh_d = alarmHigh_d & `DAFR_RSVD_MASK; // RULE_09
  end

  // Flags are overwritten by each conversion, so they clear on recovery
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_POWERUP;
      seen_q <= {`DAFR_NUM_CH{1'b0}};
      alarmLow_q <= `DAFR_ALARM_RESET; // RULE_02
      alarmHigh_q <= `DAFR_ALARM_RESET; // RULE_02
    end
    else
    begin
      state_q <= state_d;
      seen_q <= seen_d;
      alarmLow_q <= alarmLow_d; // RULE_03 RULE_11
      alarmHigh_q <= alarmHigh_d; // RULE_03 RULE_11
    end
  end

  assign powerOnBusy = ~state_q[1]; // RULE_10

  assign lowSel = (regAddr == `DAFR_ALARM_LOW_OFFSET);
  assign highSel = (regAddr == `DAFR_ALARM_HIGH_OFFSET);
  // Writes are acknowledged by the serial side but never reach storage
  assign regHit = (regSlaveAddr == `DAFR_SERIAL_ADDR) &&
                  (lowSel || highSel) && (regRead || regWrite); // RULE_11

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      regRdata <= 8'h00;
    end
    else if (regRead && regSlaveAddr == `DAFR_SERIAL_ADDR)
    begin
      if (lowSel)
      begin
        regRdata <= powerOnBusy ? `DAFR_ALARM_RESET : alarmLow_q; // RULE_01
      end
      else if (highSel)
      begin
        regRdata <= powerOnBusy ? `DAFR_ALARM_RESET :
                    (alarmHigh_q & `DAFR_RSVD_MASK); // RULE_02 RULE_09
      end
      else
      begin
        regRdata <= 8'h00;
      end
    end
  end
endmodule // dafr_alarm_flags

// *** rtl/dafr_compare.v ***
// Over and under threshold comparator for one converted value
`timescale 1ns/100ps
module dafr_compare #(
  parameter WIDTH = 16
) (
  reading,
  upperLimit,
  lowerLimit,
  overFlag,
  underFlag
);
  input wire [WIDTH-1:0] reading;
  input wire [WIDTH-1:0] upperLimit;
  input wire [WIDTH-1:0] lowerLimit;
  output wire overFlag;
  output wire underFlag;

  // Strict compares: a reading equal to a limit is still normal
  assign overFlag = (reading > upperLimit);
  assign underFlag = (reading < lowerLimit);
endmodule // dafr_compare
